// ### core/ebml_pkg.sv
// shared constants and record types for the measurement logger
package ebml_pkg;

    // ------------------------------------------------------------
    // widths of the measured and accumulated quantities
    // ------------------------------------------------------------
    localparam int V_W = 16;
    localparam int DT_W = 16;
    localparam int T_W = 32;
    localparam int AH_W = 48;
    localparam int WH_W = 64;
    localparam int STEP_W = 8;
    localparam int OHM_W = 24;
    localparam int LOST_W = 16;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // timing of the resistance tests
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int RES_DWELL_NS = 1000;
    localparam int PROBE_NS = 2000;
    // longest times, so rounded down to whole cycles
    localparam logic [CNT_W-1:0] RES_DWELL_CYC =
        CNT_W'((RES_DWELL_NS * CLK_MHZ) / 1000);
    localparam logic [CNT_W-1:0] PROBE_CYC =
        CNT_W'((PROBE_NS * CLK_MHZ) / 1000);

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [LOST_W-1:0] LOST_RST = 16'h0000;
    localparam logic [OHM_W-1:0] OHM_RST = 24'h000000;

    // ------------------------------------------------------------
    // resistance test sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RS_IDLE = 3'h1,
        RS_CELL = 3'h2,
        RS_PROBE = 3'h4
    } ebml_rs_t;

    // ------------------------------------------------------------
    // one log record as it travels through the buffer
    // ------------------------------------------------------------
    typedef struct packed {
        logic mode_cv;
        logic [STEP_W-1:0] step;
        logic [T_W-1:0] elapsed;
        logic signed [V_W-1:0] volt;
        logic signed [V_W-1:0] curr;
        logic signed [AH_W-1:0] ah;
        logic signed [WH_W-1:0] wh;
    } ebml_rec_t;

    localparam int REC_W = $bits(ebml_rec_t);

endpackage : ebml_pkg

// ### core/ebml_fifo.sv
// circular log buffer: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ebml_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // status
    output logic full
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } ebml_fst_t;

    ebml_fst_t st;
    ebml_fst_t next_st;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // handshake terms
    // ------------------------------------------------------------
    // a pop in the same cycle frees the slot, so full still accepts
    assign full = (st.cnt == (PW + 1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign in_ready = !full || out_ready;
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update, pointers wrap at depth
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : ebml_fifo

// ### core/ebml_logger.sv
// event based measurement logger with resistance test sequencer
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// [R1] each interval add current times interval length to amp-hours
// [R2] amp-hours rise while charging, fall while discharging
// [R3] each interval add current times voltage times interval to Wh
// [R4] watt-hours follow the same sign as amp-hours
// [R5] voltage trigger logs when voltage change exceeds its threshold
// [R6] current trigger logs when current change exceeds its threshold
// [R7] time trigger logs each time the time threshold is exceeded
// [R8] thresholds from zero up; zero logs every reading
// [R9] an all-ones threshold means infinity and never fires
// [R10] triggers judged once per interval, at most one record each
// [R11] any enabled trigger firing writes a record
// [R12] record holds mode, step, time, volts, amps, Ah and Wh
// [R13] full buffer: newest record overwrites the oldest
// [R14] buffer readable at any time, also during a sequence
// [R15] host drains the buffer before records get overwritten
// [R16] local sensing uses connector voltage, remote the sense leads
// [R17] cell test on command when idle or as step, after disconnect
// [R18] excitation goes to one channel at a time, others rest
// [R19] probe test only while idle, result returned in ohms
// [R20] probes checked continuously while a sequence runs
// [R21] change references are the values of the last record
// ----------------------------------------------------------------
module ebml_logger import ebml_pkg::*; #(
    parameter int NUM_CH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // measurement interval
    input wire logic meas_tick,
    input wire logic signed [V_W-1:0] volt_local,
    input wire logic signed [V_W-1:0] volt_remote,
    input wire logic signed [V_W-1:0] meas_curr,
    input wire logic [DT_W-1:0] interval_len,
    input wire logic remote_sense,
    // sequence status
    input wire logic seq_start,
    input wire logic seq_running,
    input wire logic regulation_mode_flag,
    input wire logic [STEP_W-1:0] step_num,
    // trigger setup
    input wire logic trig_dv_en,
    input wire logic trig_di_en,
    input wire logic trig_dt_en,
    input wire logic [V_W-1:0] dv_thresh,
    input wire logic [V_W-1:0] di_thresh,
    input wire logic [T_W-1:0] dt_thresh,
    // log readout
    input wire logic rd_ready,
    output logic rd_valid,
    output ebml_rec_t rd_data,
    output logic [LOST_W-1:0] log_lost,
    // resistance tests
    input wire logic cell_res_cmd,
    input wire logic cell_res_step,
    input wire logic probe_res_cmd,
    input wire logic [OHM_W-1:0] probe_ohms,
    output logic charge_disconnect,
    output logic [NUM_CH-1:0] excite_sel,
    output logic probe_meas_en,
    output logic probe_check_en,
    output logic [OHM_W-1:0] probe_result,
    output logic test_done,
    output logic cmd_refused
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ebml_rs_t rs;
        logic [CNT_W-1:0] cnt;
        logic [NUM_CH-1:0] excite;
        logic disc;
        logic probe_en;
        logic check_en;
        logic [OHM_W-1:0] ohms;
        logic done;
        logic refused;
        logic eval;
        logic signed [V_W-1:0] volt;
        logic signed [V_W-1:0] curr;
        logic [T_W-1:0] elapsed;
        logic signed [AH_W-1:0] ah;
        logic signed [WH_W-1:0] wh;
        logic signed [V_W-1:0] vref;
        logic signed [V_W-1:0] iref;
        logic [T_W-1:0] tref;
        logic rd_valid;
        ebml_rec_t rd_data;
        logic [LOST_W-1:0] lost;
    } ebml_st_t;

    ebml_st_t st;
    ebml_st_t next_st;
    logic signed [V_W-1:0] volt_sel;
    logic signed [AH_W-1:0] ah_inc;
    logic signed [WH_W-1:0] wh_inc;
    logic [V_W:0] dv_abs;
    logic [V_W:0] di_abs;
    logic [T_W-1:0] dt_el;
    logic dv_hit;
    logic di_hit;
    logic dt_hit;
    logic log_fire;
    ebml_rec_t rec;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    ebml_rec_t fifo_out_data;
    logic fifo_full;
    logic take;
    logic drop;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // magnitude of a signed difference, one bit wider so no wrap
    function automatic logic [V_W:0] abs_diff(
        input logic signed [V_W-1:0] a,
        input logic signed [V_W-1:0] b
    );
        logic signed [V_W:0] d;
        d = (V_W + 1)'(a) - (V_W + 1)'(b);
        abs_diff = d[V_W] ? (V_W + 1)'(-d) : d;
    endfunction : abs_diff

    // ------------------------------------------------------------
    // sensing and accumulation
    // ------------------------------------------------------------
    // sense point select ahead of every use of the voltage
    assign volt_sel = remote_sense ? volt_remote : volt_local; // see [R16]

    // signed current gives charge positive, discharge negative
    assign ah_inc = AH_W'(meas_curr)
        * $signed(AH_W'(interval_len)); // see [R1] see [R2]
    assign wh_inc = WH_W'(ah_inc) * WH_W'(volt_sel); // see [R3] see [R4]

    // ------------------------------------------------------------
    // trigger evaluation
    // ------------------------------------------------------------
    assign dv_abs = abs_diff(st.volt, st.vref); // see [R21]
    assign di_abs = abs_diff(st.curr, st.iref); // see [R21]
    assign dt_el = st.elapsed - st.tref; // see [R21]

    // zero logs everything, all ones never fires
    assign dv_hit = trig_dv_en && ((dv_thresh == '0) // see [R8]
        || (dv_thresh != '1 // see [R9]
        && dv_abs > {1'b0, dv_thresh})); // see [R5]
    assign di_hit = trig_di_en && ((di_thresh == '0) // see [R8]
        || (di_thresh != '1 // see [R9]
        && di_abs > {1'b0, di_thresh})); // see [R6]
    assign dt_hit = trig_dt_en && ((dt_thresh == '0) // see [R8]
        || (dt_thresh != '1 // see [R9]
        && dt_el > dt_thresh)); // see [R7]

    // judged only in the cycle after the tick, one record max
    assign log_fire = st.eval
        && (dv_hit || di_hit || dt_hit); // see [R10] see [R11]

    // record takes the freshly registered sample; mode and step come straight from the inputs
    always_comb begin
        rec.mode_cv = regulation_mode_flag; // see [R12]
        rec.step = step_num;
        rec.elapsed = st.elapsed;
        rec.volt = st.volt;
        rec.curr = st.curr;
        rec.ah = st.ah;
        rec.wh = st.wh;
    end

    // ------------------------------------------------------------
    // log buffer
    // ------------------------------------------------------------
    // output stage refills whenever empty or being read
    assign take = !st.rd_valid || rd_ready; // see [R14]
    // full buffer and no read pending: throw away the oldest
    assign drop = log_fire && fifo_full && !take; // see [R13]
    assign fifo_out_ready = take || drop;

    ebml_fifo #(
        .WIDTH(REC_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(log_fire),
        .in_ready(fifo_in_ready),
        .in_data(rec),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .full(fifo_full)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.eval = 1'b0;
        next_st.done = 1'b0;
        next_st.refused = 1'b0;
        next_st.check_en = seq_running; // see [R20]

        // a new sequence starts from zero totals
        if (seq_start) begin
            next_st.elapsed = '0;
            next_st.ah = '0;
            next_st.wh = '0;
            next_st.vref = '0;
            next_st.iref = '0;
            next_st.tref = '0;
        end else if (meas_tick) begin
            next_st.volt = volt_sel; // see [R16]
            next_st.curr = meas_curr;
            next_st.elapsed = st.elapsed + T_W'(interval_len);
            next_st.ah = st.ah + ah_inc; // see [R1]
            next_st.wh = st.wh + wh_inc; // see [R3]
            next_st.eval = 1'b1; // see [R10]
        end

        // references move only when a record is written or a new sequence starts
        if (log_fire) begin
            next_st.vref = st.volt; // see [R21]
            next_st.iref = st.curr;
            next_st.tref = st.elapsed;
        end

        // output stage of the readout
        if (take) begin
            next_st.rd_valid = fifo_out_valid;
            if (fifo_out_valid) begin
                next_st.rd_data = fifo_out_data;
            end
        end
        // saturation avoided on purpose: host sees the wrap
        if (drop) begin
            next_st.lost = st.lost + 1'b1; // see [R15]
        end

        // resistance test sequencer
        case (st.rs)
            RS_IDLE: begin
                next_st.cnt = CNT_RST;
                if (cell_res_step || (cell_res_cmd && !seq_running)) begin
                    next_st.rs = RS_CELL; // see [R17]
                    next_st.disc = 1'b1;
                end else if (probe_res_cmd && !seq_running) begin
                    next_st.rs = RS_PROBE; // see [R19]
                    next_st.probe_en = 1'b1;
                end
                if ((cell_res_cmd || probe_res_cmd) && seq_running) begin
                    next_st.refused = 1'b1; // see [R17] see [R19]
                end
            end
            RS_CELL: begin
                // circuits were opened last cycle, now excite
                if (st.excite == '0) begin
                    next_st.excite = NUM_CH'(1); // see [R17]
                end else if (st.cnt == RES_DWELL_CYC - 1'b1) begin
                    next_st.cnt = CNT_RST;
                    if (st.excite[NUM_CH-1]) begin
                        next_st.excite = '0;
                        next_st.disc = 1'b0;
                        next_st.done = 1'b1;
                        next_st.rs = RS_IDLE;
                    end else begin
                        next_st.excite = st.excite << 1; // see [R18]
                    end
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                end
            end
            RS_PROBE: begin
                if (st.cnt == PROBE_CYC - 1'b1) begin
                    next_st.ohms = probe_ohms; // see [R19]
                    next_st.probe_en = 1'b0;
                    next_st.done = 1'b1;
                    next_st.rs = RS_IDLE;
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                end
            end
            default: begin
                next_st.rs = RS_IDLE;
                next_st.excite = '0;
                next_st.disc = 1'b0;
                next_st.probe_en = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.rs <= RS_IDLE;
            st.cnt <= CNT_RST;
            st.ohms <= OHM_RST;
            st.lost <= LOST_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs come straight from the state register
    assign rd_valid = st.rd_valid;
    assign rd_data = st.rd_data;
    assign log_lost = st.lost;
    assign charge_disconnect = st.disc;
    assign excite_sel = st.excite;
    assign probe_meas_en = st.probe_en;
    assign probe_check_en = st.check_en;
    assign probe_result = st.ohms;
    assign test_done = st.done;
    assign cmd_refused = st.refused;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    ah_accumulate_a: assert property ( // see [R1]
        meas_tick && !seq_start |=> st.ah == $past(st.ah) + $past(ah_inc))
        else $error("amp-hour total not updated by increment");

    ah_sign_a: assert property ( // see [R2]
        meas_tick && !seq_start && meas_curr > 0 && interval_len != '0
        && st.ah < 0 |=> st.ah > $past(st.ah))
        else $error("amp-hours did not rise while charging");

    wh_sign_a: assert property ( // see [R4]
        meas_tick && !seq_start && meas_curr < 0 && volt_sel > 0
        && interval_len != '0 && st.wh > 0 |=> st.wh < $past(st.wh))
        else $error("watt-hours did not fall while discharging");

    zero_thresh_a: assert property ( // see [R8]
        st.eval && trig_dt_en && dt_thresh == '0 |-> log_fire)
        else $error("zero threshold did not log the reading");

    inf_thresh_a: assert property ( // see [R9]
        st.eval && trig_dv_en && dv_thresh == '1 && !trig_di_en
        && !trig_dt_en |-> !log_fire)
        else $error("infinite threshold produced a record");

    once_per_tick_a: assert property ( // see [R10]
        log_fire |-> $past(meas_tick) && !$past(seq_start))
        else $error("record written without a measurement");

    any_trigger_a: assert property ( // see [R11]
        st.eval && (dv_hit || di_hit || dt_hit) |-> log_fire)
        else $error("enabled trigger did not write a record");

    overwrite_a: assert property ( // see [R13]
        log_fire && fifo_full |-> fifo_out_ready && fifo_in_ready)
        else $error("full buffer refused the newest record");

    sense_select_a: assert property ( // see [R16]
        meas_tick && !seq_start |=> st.volt == $past(volt_sel))
        else $error("voltage not taken from selected sense point");

    disconnect_a: assert property ( // see [R17]
        excite_sel != '0 |-> charge_disconnect && $past(charge_disconnect))
        else $error("excitation before circuits disconnected");

    one_channel_a: assert property ( // see [R18]
        $onehot0(excite_sel))
        else $error("more than one channel excited");

    probe_refuse_a: assert property ( // see [R19]
        probe_res_cmd && seq_running && st.rs == RS_IDLE |=>
        cmd_refused && !probe_meas_en)
        else $error("probe test accepted during a sequence");

    probe_check_a: assert property ( // see [R20]
        seq_running |=> probe_check_en)
        else $error("probe check off during a sequence");

    ref_update_a: assert property ( // see [R21]
        log_fire |=> st.vref == $past(st.volt)
        && st.tref == $past(st.elapsed))
        else $error("references not taken from last record");

    cov_record_c: cover property (log_fire ##1 rd_valid);
    cov_overwrite_c: cover property (drop);
    cov_cell_test_c: cover property (
        st.rs == RS_CELL ##1 st.rs == RS_IDLE && test_done);
    cov_probe_test_c: cover property (
        st.rs == RS_PROBE ##1 st.rs == RS_IDLE && test_done);

endmodule : ebml_logger

// ### sim/ebml_host_model.sv
// host side model that drains the measurement log
`timescale 1ns/1ps
module ebml_host_model import ebml_pkg::*; (
    // clock, reset and stall request
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic stall,
    // log readout
    input wire logic rd_valid,
    input wire ebml_rec_t rd_data,
    output logic rd_ready
);
    ebml_rec_t got[$];

    // ready changes only after an edge; a stalled host lets the log fill
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ready <= 1'b0;
        end else begin
            if (rd_valid && rd_ready) begin
                got.push_back(rd_data);
            end
            rd_ready <= !stall;
        end
    end
endmodule : ebml_host_model

// ### sim/ebml_logger_bench.sv
// self-checking bench for the measurement logger
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
    n_errors++; $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
module ebml_logger_bench import ebml_pkg::*; ;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic meas_tick, remote_sense, seq_start, seq_running, stall;
    logic regulation_mode_flag, trig_dv_en, trig_di_en, trig_dt_en;
    logic rd_ready, rd_valid, cell_res_cmd, cell_res_step, probe_res_cmd;
    logic charge_disconnect, probe_meas_en, probe_check_en;
    logic test_done, cmd_refused;
    logic signed [V_W-1:0] volt_local, volt_remote, meas_curr, e_v, e_c;
    logic [DT_W-1:0] interval_len;
    logic [STEP_W-1:0] step_num;
    logic [V_W-1:0] dv_thresh, di_thresh;
    logic [T_W-1:0] dt_thresh;
    logic [OHM_W-1:0] probe_ohms, probe_result;
    logic [LOST_W-1:0] log_lost;
    logic [3:0] excite_sel;
    ebml_rec_t rd_data, r;
    int n_errors = 0;
    int n_compared = 0;
    int k;
    int cnt[5];
    longint e_ah, e_wh, e_el;

    always #4 ref_clk = ~ref_clk;

    ebml_logger #(.NUM_CH(4), .DEPTH(16)) ebml_logger_i (.ref_clk, .reset_n,
        .meas_tick, .volt_local, .volt_remote, .meas_curr, .interval_len,
        .remote_sense, .seq_start, .seq_running, .regulation_mode_flag,
        .step_num, .trig_dv_en, .trig_di_en, .trig_dt_en, .dv_thresh,
        .di_thresh, .dt_thresh, .rd_ready, .rd_valid, .rd_data, .log_lost,
        .cell_res_cmd, .cell_res_step, .probe_res_cmd, .probe_ohms,
        .charge_disconnect, .excite_sel, .probe_meas_en, .probe_check_en,
        .probe_result, .test_done, .cmd_refused);

    ebml_host_model ebml_host_model_i (.ref_clk, .reset_n, .stall,
        .rd_valid, .rd_data, .rd_ready);

    // ----------------------------------------------------------------
    // helper tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // new sequence: totals, elapsed time and references restart at zero
    task automatic restart();
        seq_start = 1'b1;
        cyc(1);
        seq_start = 1'b0;
        e_ah = 0;
        e_wh = 0;
        e_el = 0;
        cyc(2);
    endtask : restart

    // one measurement; remote leads read the negated value to tell apart
    task automatic tick(input logic signed [V_W-1:0] v, c);
        e_v = remote_sense ? -v : v;
        e_c = c;
        volt_local = v;
        volt_remote = -v;
        meas_curr = c;
        meas_tick = 1'b1;
        e_ah += longint'(c) * longint'(interval_len);
        e_wh += longint'(c) * longint'(interval_len) * longint'(e_v);
        e_el += longint'(interval_len);
        cyc(1);
        meas_tick = 1'b0;
        cyc(8);
    endtask : tick

    // n records expected since the last call; a single one is inspected
    task automatic want(input int n, input string s);
        `CHK("records", n, ebml_host_model_i.got.size())
        if (n == 1 && ebml_host_model_i.got.size() == 1) begin
            r = ebml_host_model_i.got.pop_front();
            `CHK("ah", e_ah[AH_W-1:0], r.ah)
            `CHK("wh", e_wh, r.wh)
            `CHK("time", e_el[T_W-1:0], r.elapsed)
            `CHK("volt", e_v, r.volt)
            `CHK("curr", e_c, r.curr)
            `CHK("status", 9'h15A, {r.mode_cv, r.step})
        end
        ebml_host_model_i.got.delete();
        $display("test %s done, mismatches so far %0d", s, n_errors);
    endtask : want

    // bounded wait for test end, counting per-channel and probe cycles
    task automatic run_test();
        cnt = '{default: 0};
        for (int i = 0; test_done !== 1'b1; i++) begin
            if (i == 3000) begin
                $display("FAIL timeout waiting for test end");
                n_errors++;
                tally_and_finish();
            end
            if (probe_meas_en === 1'b1) cnt[4]++;
            if (excite_sel !== 4'h0) begin
                `CHK("onehot", 1'b1, $onehot(excite_sel))
                `CHK("disc", 1'b1, charge_disconnect)
                cnt[$clog2(excite_sel)]++;
            end
            cyc(1);
        end
        cyc(2);
    endtask : run_test

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {meas_tick, remote_sense, seq_start, seq_running, stall} = '0;
        {trig_dv_en, trig_di_en, trig_dt_en} = '0;
        {cell_res_cmd, cell_res_step, probe_res_cmd} = '0;
        {volt_local, volt_remote, meas_curr} = '0;
        regulation_mode_flag = 1'b1;
        step_num = 8'h5A;
        interval_len = 16'h000A;
        {dv_thresh, di_thresh, dt_thresh} = '1;
        probe_ohms = 24'h00ABCD;
        cyc(3);
        reset_n = 1'b1;
        cyc(2);
        `CHK("lost at reset", 16'h0000, log_lost)
        trig_dv_en = 1'b1;
        dv_thresh = 16'h0000;
        restart();
        tick(16'sh0000, 16'sh0005);
        want(1, "zero threshold");
        remote_sense = 1'b1;
        tick(16'sh0030, -16'sh0007);
        want(1, "remote discharge");
        tick(16'sh0010, 16'sh0003);
        want(1, "charge from negative");
        remote_sense = 1'b0;
        dv_thresh = 16'h0064;
        restart();
        tick(16'sh0064, 16'sh0000);
        want(0, "dv at threshold");
        tick(16'sh0065, 16'sh0000);
        want(1, "dv above");
        tick(16'sh0000, 16'sh0000);
        want(1, "dv from last record");
        trig_dv_en = 1'b0;
        trig_di_en = 1'b1;
        di_thresh = 16'h0032;
        restart();
        tick(16'sh0000, -16'sh0032);
        want(0, "di at threshold");
        tick(16'sh0000, -16'sh0033);
        want(1, "di above");
        {trig_dv_en, trig_di_en, trig_dt_en} = 3'b101;
        dv_thresh = 16'hFFFF;
        dt_thresh = 32'h0000000F;
        restart();
        tick(16'sh0009, 16'sh0001);
        want(0, "dt not yet");
        tick(16'sh7000, 16'sh0001);
        want(1, "dt exceeded");
        {trig_dv_en, trig_di_en, trig_dt_en} = 3'b111;
        {dv_thresh, di_thresh, dt_thresh} = '1;
        tick(16'sh7FFF, 16'sh7FFF);
        want(0, "infinite thresholds");
        seq_running = 1'b1;
        cyc(2);
        `CHK("probe check", 1'b1, probe_check_en)
        probe_res_cmd = 1'b1;
        cyc(1);
        probe_res_cmd = 1'b0;
        k = 0;
        repeat (3) begin
            if (cmd_refused === 1'b1) k++;
            cyc(1);
        end
        `CHK("refused", 1, k)
        cell_res_step = 1'b1;
        cyc(1);
        cell_res_step = 1'b0;
        run_test();
        `CHK("step dwell", int'(RES_DWELL_CYC), cnt[3])
        {trig_dv_en, trig_di_en, trig_dt_en} = 3'b100;
        dv_thresh = 16'h0000;
        stall = 1'b1;
        restart();
        repeat (20) tick(16'sh0000, 16'sh0001);
        stall = 1'b0;
        cyc(40);
        `CHK("kept", 20, ebml_host_model_i.got.size() + log_lost)
        `CHK("lost", 16'h0003, log_lost)
        r = ebml_host_model_i.got[1];
        `CHK("oldest", 32'h00000032, r.elapsed)
        want(17, "overwrite");
        seq_running = 1'b0;
        cyc(2);
        probe_res_cmd = 1'b1;
        cyc(1);
        probe_res_cmd = 1'b0;
        run_test();
        `CHK("probe time", int'(PROBE_CYC), cnt[4])
        `CHK("ohms", 24'h00ABCD, probe_result)
        cell_res_cmd = 1'b1;
        cyc(1);
        cell_res_cmd = 1'b0;
        run_test();
        for (k = 0; k < 4; k++) begin
            `CHK("dwell", int'(RES_DWELL_CYC), cnt[k])
        end
        `CHK("reconnect", 1'b0, charge_disconnect)
        $display("test resistance done, mismatches so far %0d", n_errors);
        tally_and_finish();
    end
endmodule : ebml_logger_bench
